// File: mla_top.v
// macrocell logic array: switch matrix, product arrays, allocators, pin cells
`timescale 1ns/1ns
`include "mla_regs.vh"
module mla_top (
   // clock and reset
   input  wire          sys_clk,
   input  wire          rst_n,
   // device pins
   input  wire [47:0]   ioIn,
   input  wire [3:0]    dedIn,
   input  wire [3:0]    clkPin,
   output wire [47:0]   ioOut,
   output wire [47:0]   ioOe,
   // switch matrix selects, 8 blocks x 26 inputs x 8 bits
   input  wire [1663:0] mtxCfg,
   // and array, 8 blocks x 52 terms x 52 literal bits
   input  wire [21631:0] andCfg,
   // term group steering, 8 blocks x 12 groups x 3 bits
   input  wire [287:0]  grpCfg,
   // macrocell setup, 8 blocks x 12 cells x 6 bits
   input  wire [575:0]  mcCfg,
   // pin driver setup, 8 blocks x 6 pins x 2 bits
   input  wire [95:0]   ioCfg,
   // status
   output wire [95:0]   mcState,
   output wire [7:0]    blkRst,
   output wire [7:0]    blkSet
);
   localparam NB   = `MLA_BLOCKS;
   localparam NMC  = `MLA_MC_PER_BLK;
   localparam NIO  = `MLA_IO_PER_BLK;
   localparam NIN  = `MLA_ARR_INS;
   localparam NPT  = `MLA_ALL_TERMS;
   localparam NGRP = `MLA_GROUPS;
   localparam GSZ  = `MLA_GRP_SIZE;
   localparam SW   = `MLA_SEL_W;
   localparam NPIN = `MLA_PIN_BITS;

   // pick one matrix source, out of range reads low
   function mtxPick;
      input [151:0] src;
      input [7:0]   idx;
      begin
         if (idx < 8'h98) begin
            mtxPick = src[idx];
         end else begin
            mtxPick = 1'b0;
         end
      end
   endfunction

   // one product term; a term with no literal is false
   function pterm;
      input [25:0] v;
      input [51:0] m;
      integer      i;
      reg          r;
      reg          any;
      begin
         r   = 1'b1;
         any = 1'b0;
         for (i = 0; i < 26; i = i + 1) begin
            if (m[2*i]) begin
               any = 1'b1;
               r   = r & v[i];
            end
            if (m[2*i+1]) begin
               any = 1'b1;
               r   = r & ~v[i];
            end
         end
         pterm = r & any;
      end
   endfunction

   // pin driver enable decode
   function oeDecode;
      input [1:0] mode;
      input       term0;
      input       term1;
      begin
         case (mode)
            `MLA_OE_OFF: begin
               oeDecode = 1'b0;
            end
            `MLA_OE_ON: begin
               oeDecode = 1'b1;
            end
            `MLA_OE_TERM0: begin
               oeDecode = term0;
            end
            `MLA_OE_TERM1: begin
               oeDecode = term1;
            end
            default: begin
               oeDecode = 1'b0;
            end
         endcase
      end
   endfunction

   // pin synchronisers
   reg  [55:0]  pinS1_q;
   reg  [55:0]  pinS2_q;
   reg  [3:0]   clkS3_q;
   wire [55:0]  pinRaw;
   wire [3:0]   clkLvl;
   wire [3:0]   clkRise;

   // outputs and status
   reg  [47:0]  ioOut_q;
   reg  [47:0]  ioOe_q;
   reg  [95:0]  mcState_q;
   reg  [7:0]   blkRst_q;
   reg  [7:0]   blkSet_q;

   // matrix sources
   wire [95:0]  mcFb;
   wire [151:0] srcVec;
   wire [47:0]  ioOeD;
   wire [47:0]  ioOutD;
   wire [7:0]   blkRstD;
   wire [7:0]   blkSetD;

   assign pinRaw = {clkPin, dedIn, ioIn};

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // start at the idle level so a high clock pin gives no false rise
         pinS1_q <= {NPIN{`MLA_PIN_IDLE}};
         pinS2_q <= {NPIN{`MLA_PIN_IDLE}};
         clkS3_q <= {`MLA_CLK_PINS{`MLA_PIN_IDLE}};
      end else begin
         pinS1_q <= pinRaw;
         pinS2_q <= pinS1_q;
         clkS3_q <= pinS2_q[55:52];
      end
   end

   assign clkLvl  = pinS2_q[55:52];
   assign clkRise = clkLvl & ~clkS3_q;

   // io pins, dedicated inputs, clock pins as data, then macrocell feedback
   assign srcVec = {mcFb, pinS2_q};

   genvar b;
   genvar i;
   genvar t;
   genvar g;
   genvar k;
   genvar j;
   genvar p;
   generate
      for (b = 0; b < NB; b = b + 1) begin : gBlk
         wire [25:0] arrIn;
         wire [51:0] pt;
         wire [11:0] grp;

         // matrix delivers 26 inputs
         for (i = 0; i < NIN; i = i + 1) begin : gIn
            assign arrIn[i] = mtxPick(srcVec, mtxCfg[(b*NIN+i)*SW +: SW]);
         end

         // 48 logic terms and 4 special terms
         for (t = 0; t < NPT; t = t + 1) begin : gPt
            assign pt[t] = pterm(arrIn, andCfg[(b*NPT+t)*52 +: 52]);
         end

         // groups of four consecutive terms
         for (g = 0; g < NGRP; g = g + 1) begin : gGrp
            assign grp[g] = |pt[g*GSZ +: GSZ];
         end

         // twelve macrocells, even ones own a pin
         for (k = 0; k < NMC; k = k + 1) begin : gMc
            wire [3:0] take;
            wire       sum;
            wire       res;
            for (j = 0; j < 4; j = j + 1) begin : gWin
               localparam integer GI = k - 1 + j;
               localparam integer SI = 3 - j;
               localparam [1:0]   STEER = SI[1:0];
               if (GI >= 0 && GI < NGRP) begin : gOk
                  // a group steers to at most one macrocell, none when disabled or steered past the block ends
                  assign take[j] = grp[GI] & grpCfg[(b*NGRP+GI)*`MLA_GRP_W + `MLA_GRP_EN]
                                   & (grpCfg[(b*NGRP+GI)*`MLA_GRP_W + `MLA_GRP_STEER +: 2] == STEER);
               end else begin : gNo
                  assign take[j] = 1'b0;
               end
            end
            assign sum = |take;

            mla_macrocell #(
               .BURIED (k % 2)
            ) uCell (
               .sys_clk (sys_clk),
               .rst_n   (rst_n),
               .sumIn   (sum),
               .pinIn   (pinS2_q[b*NIO + k/2]),
               .clkRise (clkRise),
               .gateLvl (clkLvl),
               .aRst    (pt[`MLA_PT_ARST]),
               .aSet    (pt[`MLA_PT_ASET]),
               .cfg     (mcCfg[(b*NMC+k)*`MLA_MC_W +: `MLA_MC_W]),
               .result  (res)
            );
            assign mcFb[b*NMC+k] = res;
         end

         // pin cells driven by the even macrocells
         for (p = 0; p < NIO; p = p + 1) begin : gIo
            assign ioOutD[b*NIO+p] = mcFb[b*NMC+2*p];
            assign ioOeD[b*NIO+p]  = oeDecode(ioCfg[(b*NIO+p)*`MLA_OE_W +: `MLA_OE_W],
                                              pt[`MLA_PT_OE0], pt[`MLA_PT_OE1]);
         end

         assign blkRstD[b] = pt[`MLA_PT_ARST];
         assign blkSetD[b] = pt[`MLA_PT_ASET];
      end
   endgenerate

   // registered pins and status
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ioOut_q   <= 48'h0;
         ioOe_q    <= 48'h0;
         mcState_q <= 96'h0;
         blkRst_q  <= 8'h0;
         blkSet_q  <= 8'h0;
      end else begin
         ioOut_q   <= ioOutD;
         ioOe_q    <= ioOeD;
         mcState_q <= mcFb;
         blkRst_q  <= blkRstD;
         blkSet_q  <= blkSetD;
      end
   end

   assign ioOut   = ioOut_q;
   assign ioOe    = ioOe_q;
   assign mcState = mcState_q;
   assign blkRst  = blkRst_q;
   assign blkSet  = blkSet_q;
endmodule // mla_top

// File: mla_regs.vh
// constants and field layout of the macrocell logic array
`ifndef MLA_REGS_VH
`define MLA_REGS_VH
// sizes
`define MLA_BLOCKS      8
`define MLA_IO_PINS     48
`define MLA_DED_PINS    4
`define MLA_CLK_PINS    4
`define MLA_PIN_BITS    56
`define MLA_MC_PER_BLK  12
`define MLA_IO_PER_BLK  6
`define MLA_ARR_INS     26
`define MLA_LOGIC_TERMS 48
`define MLA_ALL_TERMS   52
`define MLA_GRP_SIZE    4
`define MLA_GROUPS      12
`define MLA_SRC_COUNT   152
`define MLA_SEL_W       8
// special product term positions
`define MLA_PT_OE0      48
`define MLA_PT_OE1      49
`define MLA_PT_ARST     50
`define MLA_PT_ASET     51
// group steering field: [1:0] steer, [2] enable
`define MLA_GRP_W       3
`define MLA_GRP_STEER   0
`define MLA_GRP_EN      2
// macrocell config field: [1:0] mode, [2] polarity, [4:3] clock, [5] pin input
`define MLA_MC_W        6
`define MLA_MC_MODE     0
`define MLA_MC_POL      2
`define MLA_MC_CLK      3
`define MLA_MC_PIN      5
`define MLA_MODE_COMB   2'h0
`define MLA_MODE_DREG   2'h1
`define MLA_MODE_TREG   2'h2
`define MLA_MODE_LATCH  2'h3
// pin driver field
`define MLA_OE_W        2
`define MLA_OE_OFF      2'h0
`define MLA_OE_ON       2'h1
`define MLA_OE_TERM0    2'h2
`define MLA_OE_TERM1    2'h3
// reset values
`define MLA_RST_STATE   1'b0
// pins idle high on their pull-ups, so synchronisers start high
`define MLA_PIN_IDLE    1'b1
`endif

// File: mla_macrocell.v
// one macrocell: combinational, d or toggle register, latch, polarity
`timescale 1ns/1ns
`include "mla_regs.vh"
module mla_macrocell #(
   parameter BURIED = 0
) (
   // clock and reset
   input  wire       sys_clk,
   input  wire       rst_n,
   // data
   input  wire       sumIn,
   input  wire       pinIn,
   // shared clock pins
   input  wire [3:0] clkRise,
   input  wire [3:0] gateLvl,
   // block terms
   input  wire       aRst,
   input  wire       aSet,
   // configuration
   input  wire [5:0] cfg,
   // result
   output wire       result
);
   reg        state_q;
   wire [1:0] mode;
   wire [1:0] clkSel;
   wire       dIn;
   wire       edgeHit;
   wire       gateHigh;

   assign mode     = cfg[`MLA_MC_MODE +: 2];
   assign clkSel   = cfg[`MLA_MC_CLK +: 2];
   assign edgeHit  = clkRise[clkSel];
   assign gateHigh = gateLvl[clkSel];
   // buried cells may take the pin instead of the sum
   assign dIn = (BURIED != 0 && cfg[`MLA_MC_PIN]) ? pinIn : sumIn;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= `MLA_RST_STATE;
      end else if (mode != `MLA_MODE_COMB && aRst) begin
         state_q <= 1'b0;
      end else if (mode != `MLA_MODE_COMB && aSet) begin
         state_q <= 1'b1;
      end else begin
         case (mode)
            `MLA_MODE_COMB: begin
               state_q <= dIn;
            end
            `MLA_MODE_DREG: begin
               if (edgeHit) begin
                  state_q <= dIn;
               end
            end
            `MLA_MODE_TREG: begin
               if (edgeHit && dIn) begin
                  state_q <= ~state_q;
               end
            end
            `MLA_MODE_LATCH: begin
               if (!gateHigh) begin
                  state_q <= dIn;
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   assign result = state_q ^ cfg[`MLA_MC_POL];
endmodule // mla_macrocell

// File: mla_asserts.sv
// port assertions for the macrocell logic array
`timescale 1ns/1ns
module mla_asserts (
   // clock and reset
   input wire logic         sys_clk,
   input wire logic         rst_n,
   // pins, setup, status
   input wire logic [3:0]   clkPin,
   input wire logic [47:0]  ioOut,
   input wire logic [47:0]  ioOe,
   input wire logic [575:0] mcCfg,
   input wire logic [95:0]  ioCfg,
   input wire logic [95:0]  mcState,
   input wire logic [7:0]   blkRst,
   input wire logic [7:0]   blkSet
);
   logic [47:0] evenSt;
   wire         quiet = !blkRst[0] && !blkSet[0];
   always_comb
      for (int n = 0; n < 48; n++)
         evenSt[n] = mcState[(n / 6) * 12 + (n % 6) * 2];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_dIdle;
      (mcCfg[5:0] == 6'h01 && !clkPin[0] && quiet) [*4];
   endsequence
   sequence s_gateHi;
      (mcCfg[5:0] == 6'h03 && clkPin[0] && quiet) [*4];
   endsequence
   property p_oeOn;
      (ioCfg[1:0] == 2'h1) [*3] |-> ioOe[0];
   endproperty
   property p_oeOff;
      (ioCfg[1:0] == 2'h0) [*3] |-> !ioOe[0];
   endproperty
   property p_rstWins;
      (blkRst[0] && mcCfg[1:0] != 2'h0 && !mcCfg[2]) [*3] |-> !mcState[0];
   endproperty
   property p_set;
      (blkSet[0] && !blkRst[0] && mcCfg[1:0] != 2'h0 && !mcCfg[2]) [*3] |-> mcState[0];
   endproperty
   property p_pins;
      1'b1 |-> ioOut == evenSt;
   endproperty
   property p_dHold;
      s_dIdle ##1 quiet [*2] |-> $past(mcState[0]) == $past(mcState[0], 2);
   endproperty
   property p_gateHold;
      s_gateHi ##1 quiet [*2] |-> $past(mcState[0]) == $past(mcState[0], 2);
   endproperty
   property p_first;
      $rose(rst_n) |-> ioOut == 48'h0 && ioOe == 48'h0 && mcState == 96'h0;
   endproperty
   a_oeOn: assert property (p_oeOn) else $error("pin driver not on");
   a_oeOff: assert property (p_oeOff) else $error("pin driver not off");
   a_rstWins: assert property (p_rstWins) else $error("reset term not applied");
   a_set: assert property (p_set) else $error("preset term not applied");
   a_pins: assert property (p_pins) else $error("pin value differs from cell");
   a_dHold: assert property (p_dHold) else $error("register moved without edge");
   a_gateHold: assert property (p_gateHold) else $error("latch moved with gate high");
   a_first: assert property (p_first) else $error("outputs not clear after reset");
endmodule // mla_asserts
bind mla_top mla_asserts mla_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n), .clkPin(clkPin),
   .ioOut(ioOut), .ioOe(ioOe), .mcCfg(mcCfg), .ioCfg(ioCfg), .mcState(mcState),
   .blkRst(blkRst), .blkSet(blkSet));

// File: mla_board.sv
// board logic driving and reading the io pins
`timescale 1ns/1ns
module mla_board (
   // device side
   input  wire logic [47:0] ioOut,
   input  wire logic [47:0] ioOe,
   output wire logic [47:0] ioIn,
   // board side
   input  wire logic [47:0] drv,
   input  wire logic [47:0] drvEn
);
   // device driver wins, then board, else pull-up
   assign ioIn = (ioOe & ioOut) | (~ioOe & drvEn & drv) | (~ioOe & ~drvEn);
endmodule // mla_board

// File: tb_macrocell_logic_array.sv
// self-checking bench for the macrocell logic array
`timescale 1ns/1ns
module tb_macrocell_logic_array;
   logic           sys_clk = 1'b0;
   logic           rst_n = 1'b0;
   logic [47:0]    ioIn;
   logic [47:0]    ioOut;
   logic [47:0]    ioOe;
   logic [47:0]    drv = 48'h0;
   logic [3:0]     dedIn = 4'h0;
   logic [3:0]     clkPin = 4'h0;
   logic [1663:0]  mtxCfg = 1664'h0;
   logic [21631:0] andCfg = 21632'h0;
   logic [287:0]   grpCfg = 288'h0;
   logic [575:0]   mcCfg = 576'h0;
   logic [95:0]    ioCfg = 96'h0;
   logic [95:0]    mcState;
   logic [7:0]     blkRst;
   logic [7:0]     blkSet;
   int             mismatches = 0;
   int             samplesChecked = 0;
   int             cycles = 0;
   always #25 sys_clk = ~sys_clk;
   mla_top mla_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .ioIn(ioIn), .dedIn(dedIn), .clkPin(clkPin),
      .ioOut(ioOut), .ioOe(ioOe), .mtxCfg(mtxCfg), .andCfg(andCfg), .grpCfg(grpCfg), .mcCfg(mcCfg),
      .ioCfg(ioCfg), .mcState(mcState), .blkRst(blkRst), .blkSet(blkSet));
   mla_board mla_board_i (.ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .drv(drv), .drvEn(48'h1001));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      samplesChecked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   // drive pins 0 and 12 and the clock pins, settle, check pin 0
   task automatic step(input logic d, input logic [3:0] c, input logic exp);
      drv[0] = d;
      drv[12] = d;
      clkPin = c;
      repeat (5) @(posedge sys_clk);
      #5;
      chk(ioOut[0], exp);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         end_sim;
      end
   end
   initial begin
      mtxCfg[23:0] = 24'h31300c;
      andCfg[0] = 1'b1;
      andCfg[2496] = 1'b1;
      andCfg[2602] = 1'b1;
      andCfg[2656] = 1'b1;
      grpCfg[2:0] = 3'h6;
      ioCfg[1:0] = 2'h1;
      repeat (20) @(posedge sys_clk);
      #5;
      rst_n = 1'b1;
      step(1'b1, 4'h0, 1'b1);
      chk(mcState[0], 1'b1);
      step(1'b0, 4'h0, 1'b0);
      mcCfg[2] = 1'b1;
      step(1'b0, 4'h0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         mcCfg[5:0] = {1'b0, 2'(k), 3'h1};
         step(1'b0, 4'h1 << k, 1'b0);
         step(1'b1, ~(4'h1 << k), 1'b0);
         step(1'b1, 4'hf, 1'b1);
         step(1'b0, 4'h0, 1'b1);
      end
      mcCfg[5:0] = 6'h02;
      dedIn[0] = 1'b1;
      step(1'b1, 4'h0, 1'b0);
      chk(blkRst[0], 1'b1);
      dedIn[0] = 1'b0;
      step(1'b1, 4'h0, 1'b0);
      step(1'b1, 4'h1, 1'b1);
      step(1'b1, 4'h0, 1'b1);
      step(1'b1, 4'h1, 1'b0);
      step(1'b0, 4'h0, 1'b0);
      step(1'b0, 4'h1, 1'b0);
      mcCfg[5:0] = 6'h03;
      mcCfg[17:12] = 6'h03;
      step(1'b1, 4'h0, 1'b1);
      step(1'b0, 4'h0, 1'b0);
      step(1'b0, 4'h1, 1'b0);
      step(1'b1, 4'h1, 1'b0);
      dedIn[1] = 1'b1;
      step(1'b1, 4'h1, 1'b1);
      chk(mcState[2], 1'b1);
      chk(blkSet[0], 1'b1);
      dedIn[0] = 1'b1;
      step(1'b1, 4'h1, 1'b0);
      dedIn = 4'h0;
      step(1'b1, 4'h1, 1'b0);
      step(1'b1, 4'h0, 1'b1);
      mcCfg[5:0] = 6'h00;
      for (int c = 0; c < 4; c++)
         for (int d = 0; d < 2; d++) begin
            ioCfg[1:0] = 2'(c);
            step(1'(d), 4'h0, 1'(d));
            chk(ioOe[0], 1'(c == 1 || (c == 2 && d == 1)));
         end
      ioCfg[1:0] = 2'h0;
      mtxCfg[7:0] = 8'h00;
      mcCfg[11:6] = 6'h21;
      step(1'b1, 4'h1, 1'b1);
      chk(mcState[1], 1'b1);
      step(1'b0, 4'h0, 1'b0);
      chk(mcState[1], 1'b1);
      step(1'b0, 4'h1, 1'b0);
      chk(mcState[1], 1'b0);
      end_sim;
   end
endmodule // tb_macrocell_logic_array
